// ---- verilog/async_host_command_port.sv ----
// asynchronous 8-bit host command port with acknowledge handshake
`include "host_port_params.svh"

// Behaviour
// R1: the host link is an 8-bit parallel port with a request/acknowledge handshake and no clock.
// R2: bytes are accepted no faster than ten megabytes per second.
// R3: the host gives each controller its own strobe and never lowers two at once.
// R4: the select strobe is active low, idles high, and each transfer starts on its falling edge.
// R5: direction high means read and the device drives data, low means write.
// R6: a written byte is a command when cmd_data_sel is high and an argument when it is low.
// R7: the acknowledge is released to high impedance whenever the strobe is high.
// R8: wake and direction are only looked at while the strobe is low.
// R9: the host sets data and qualifiers stable before lowering the strobe.
// R10: wake high under a low strobe takes the device out of standby.
// R11: the host reset is active low and asynchronous.
// R12: the data bus is eight bits with bit zero the least significant.
// R13: the acknowledge goes high at the strobe fall and low once the transfer is complete.
// R14: a command arriving while arguments are being loaded aborts that argument load.
// R15: the strobe and other host inputs are synchronised before use.
// R16: data drivers stay off while the strobe is high or the direction is write.
module async_host_command_port
    import host_port_pkg::*;
(
    input wire logic clk,
    input wire logic rst_b,
    input wire logic select_strobe_n,
    input wire logic read_not_write,
    input wire logic cmd_data_sel,
    input wire logic wake_request,
    input wire logic [`HP_DATA_W-1:0] host_data_in,
    output logic [`HP_DATA_W-1:0] host_data_out,
    output logic host_data_oe,
    output logic ack_n_out,
    output logic ack_oe,
    output logic rx_valid,
    input wire logic rx_ready,
    output logic [`HP_DATA_W-1:0] rx_byte,
    output logic rx_is_cmd,
    output logic args_abort,
    input wire logic tx_valid,
    input wire logic [`HP_DATA_W-1:0] tx_byte,
    output logic tx_taken,
    input wire logic in_standby,
    output logic wake_pulse
);

    // ****************************************
    // input synchronisers
    // ****************************************

    logic [`HP_SYNC_W-1:0] sync1_r;
    logic [`HP_SYNC_W-1:0] sync2_r;
    logic ds_prev_r;
    logic ds_s;
    logic rw_s;
    logic cd_s;
    logic wake_s;
    host_byte_t data_s;
    logic ds_fall;

    // two flops on every pin; data is stable by the time the strobe lands
    always_ff @(posedge clk or negedge rst_b) begin // R11
        if (!rst_b) begin
            sync1_r <= {`HP_SYNC_W{1'b1}};
            sync2_r <= {`HP_SYNC_W{1'b1}};
        end else begin
            sync1_r <= {wake_request, cmd_data_sel, read_not_write, select_strobe_n,
                        host_data_in}; // R15
            sync2_r <= sync1_r;
        end
    end

    assign data_s = sync2_r[`HP_DATA_W-1:0]; // R1 R12
    assign ds_s = sync2_r[`HP_SYNC_DS];
    assign rw_s = sync2_r[`HP_SYNC_RW];
    assign cd_s = sync2_r[`HP_SYNC_CD];
    assign wake_s = sync2_r[`HP_SYNC_WAKE];

    // falling strobe edge, seen only on synchronised copies
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            ds_prev_r <= 1'b1;
        end else begin
            ds_prev_r <= ds_s;
        end
    end

    assign ds_fall = ds_prev_r && !ds_s; // R4

    // ****************************************
    // byte pacing
    // ****************************************

    logic [3:0] gap_cnt_r;
    logic gap_ok;
    logic byte_done;

    assign gap_ok = (gap_cnt_r == 4'h0);

    // holds off the next byte until the rate ceiling allows it
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            gap_cnt_r <= 4'h0;
        end else if (byte_done) begin
            gap_cnt_r <= 4'(`HP_BYTE_CYC - 1); // R2
        end else if (!gap_ok) begin
            gap_cnt_r <= gap_cnt_r - 4'h1;
        end
    end

    // ****************************************
    // transfer sequencer
    // ****************************************

    port_state_t state_r;
    logic buf_in_ready;
    logic push;

    // write is taken as soon as the buffer has room; a full buffer stalls the ack
    assign push = (state_r == ST_WRITE) && !ds_s && buf_in_ready && gap_ok;
    assign byte_done = push || ((state_r == ST_READ) && !ds_s && tx_valid && gap_ok);

    // direction and wake are sampled once, at the strobe fall only
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state_r <= ST_IDLE;
        end else if (ds_s && state_r != ST_IDLE) begin
            state_r <= ST_IDLE; // R7
        end else begin
            unique case (state_r)
                ST_IDLE: begin
                    if (ds_fall) begin
                        if (wake_s) begin
                            state_r <= ST_WAKE; // R8
                        end else if (rw_s) begin
                            state_r <= ST_READ; // R5
                        end else begin
                            state_r <= ST_WRITE;
                        end
                    end
                end
                ST_WRITE: begin
                    if (push) begin
                        state_r <= ST_DONE;
                    end
                end
                ST_READ: begin
                    if (byte_done) begin
                        state_r <= ST_DONE;
                    end
                end
                ST_WAKE: begin
                    if (!in_standby) begin
                        state_r <= ST_DONE;
                    end
                end
                ST_DONE: begin
                    state_r <= ST_DONE;
                end
            endcase
        end
    end

    // ****************************************
    // acknowledge and data drivers
    // ****************************************

    // ack driven high at the fall, low at completion, released with the strobe
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            ack_oe <= 1'b0;
            ack_n_out <= `HP_ACK_RST;
        end else if (ds_s) begin
            ack_oe <= 1'b0; // R7
            ack_n_out <= `HP_ACK_RST;
        end else if (ds_fall) begin
            ack_oe <= 1'b1; // R13
            ack_n_out <= 1'b1;
        end else if (byte_done || (state_r == ST_WAKE && !in_standby)) begin
            ack_n_out <= 1'b0; // R13
        end
    end

    // read data and its enable land on the same edge as the ack fall
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            host_data_out <= `HP_DATA_RST;
            host_data_oe <= 1'b0;
        end else if (ds_s || !rw_s) begin
            host_data_oe <= 1'b0; // R16
        end else if (state_r == ST_READ && byte_done) begin
            host_data_out <= tx_byte;
            host_data_oe <= 1'b1; // R5
        end
    end

    // one-cycle pulse to the source of read bytes
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            tx_taken <= 1'b0;
        end else begin
            tx_taken <= (state_r == ST_READ) && byte_done;
        end
    end

    // ****************************************
    // wake and argument abort
    // ****************************************

    logic args_loading_r;

    // wake only counts under a low strobe; a pulse per qualifying fall
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            wake_pulse <= 1'b0;
        end else begin
            wake_pulse <= (state_r == ST_IDLE) && ds_fall && wake_s; // R10
        end
    end

    // loading is open from the first argument until the next command
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            args_loading_r <= 1'b0;
        end else if (push) begin
            args_loading_r <= !cd_s;
        end
    end

    // abort pulse rides alongside the buffered command that causes it
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            args_abort <= 1'b0;
        end else begin
            args_abort <= push && cd_s && args_loading_r; // R14
        end
    end

    // ****************************************
    // received word buffer
    // ****************************************

    logic [`HP_WORD_W-1:0] buf_out;
    logic buf_out_valid;
    logic out_take;

    word_buffer2 u_rx_buf (
        .clk(clk),
        .rst_b(rst_b),
        .in_valid(push),
        .in_ready(buf_in_ready),
        .in_data({cd_s, data_s}), // R6
        .out_valid(buf_out_valid),
        .out_ready(out_take),
        .out_data(buf_out)
    );

    // output stage flop keeps the user outputs registered
    assign out_take = buf_out_valid && (!rx_valid || rx_ready);

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rx_valid <= 1'b0;
            rx_byte <= `HP_DATA_RST;
            rx_is_cmd <= 1'b0;
        end else if (out_take) begin
            rx_valid <= 1'b1;
            rx_byte <= buf_out[`HP_DATA_W-1:0];
            rx_is_cmd <= buf_out[`HP_CMD_BIT];
        end else if (rx_ready) begin
            rx_valid <= 1'b0;
        end
    end

    // ****************************************
    // assertions
    // ****************************************

    a_ack_release: assert property (@(posedge clk) disable iff (!rst_b) // R7
        ds_s |=> !ack_oe) else $error("ack driven while strobe high");

    a_ack_start: assert property (@(posedge clk) disable iff (!rst_b) // R13
        ds_fall |=> ack_oe && ack_n_out) else $error("ack not high after strobe fall");

    a_write_ack: assert property (@(posedge clk) disable iff (!rst_b) // R13
        push |=> !ack_n_out ##1 (ds_s || !ack_n_out)) else $error("write not acknowledged");

    a_data_drive: assert property (@(posedge clk) disable iff (!rst_b) // R16
        host_data_oe |-> !$past(ds_s) && $past(rw_s)) else $error("data driven on write or idle");

    a_read_data: assert property (@(posedge clk) disable iff (!rst_b) // R5
        tx_taken |-> host_data_oe && !ack_n_out && host_data_out == $past(tx_byte))
        else $error("read byte not presented with ack");

    a_cmd_flag: assert property (@(posedge clk) disable iff (!rst_b) // R6
        (push && !buf_out_valid && (!rx_valid || rx_ready)) |=> ##1 rx_is_cmd == $past(cd_s, 2))
        else $error("command flag lost");

    a_arg_abort: assert property (@(posedge clk) disable iff (!rst_b) // R14
        (push && cd_s && args_loading_r) |=> args_abort && !args_loading_r)
        else $error("argument load not aborted");

    a_wake_gate: assert property (@(posedge clk) disable iff (!rst_b) // R8
        wake_pulse |-> !$past(ds_s) && $past(wake_s)) else $error("wake taken without strobe");

    a_wake_exit: assert property (@(posedge clk) disable iff (!rst_b) // R10
        (state_r == ST_IDLE && ds_fall && wake_s) |=> wake_pulse && state_r == ST_WAKE)
        else $error("wake request ignored");

    a_byte_pace: assert property (@(posedge clk) disable iff (!rst_b) // R2
        byte_done |=> !byte_done) else $error("bytes closer than rate ceiling");

endmodule : async_host_command_port

// ---- verilog/host_port_params.svh ----
// constants for the asynchronous host command port
`ifndef HOST_PORT_PARAMS_SVH
`define HOST_PORT_PARAMS_SVH

// host data bus width
`define HP_DATA_W 8
// flag bit of a buffered word: high for a command byte
`define HP_CMD_BIT 8
// buffered word width: flag plus byte
`define HP_WORD_W 9
// synchronised inputs: data, strobe, direction, cmd/data, wake
`define HP_SYNC_W 12
// field positions inside the synchronised vector
`define HP_SYNC_DS 8
`define HP_SYNC_RW 9
`define HP_SYNC_CD 10
`define HP_SYNC_WAKE 11
// internal clock rate and sustained byte ceiling
`define HP_CLK_HZ 10000000
`define HP_BYTE_NS 100
`define HP_CLK_NS 100
// least spacing between bytes in cycles, rounded up
`define HP_BYTE_CYC ((`HP_BYTE_NS + `HP_CLK_NS - 1) / `HP_CLK_NS)
// reset values of the pin-facing flops
`define HP_ACK_RST 1'b1
`define HP_DATA_RST 8'h00

`endif

// ---- verilog/host_port_pkg.sv ----
// types shared by the host command port
package host_port_pkg;

    // transfer sequencer states, one-hot
    typedef enum logic [4:0] {
        ST_IDLE  = 5'h01,
        ST_WRITE = 5'h02,
        ST_READ  = 5'h04,
        ST_WAKE  = 5'h08,
        ST_DONE  = 5'h10
    } port_state_t;

    typedef logic [7:0] host_byte_t;

endpackage : host_port_pkg

// ---- verilog/word_buffer2.sv ----
// two-entry valid/ready buffer for received host words
`include "host_port_params.svh"

module word_buffer2 (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [`HP_WORD_W-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [`HP_WORD_W-1:0] out_data
);

    logic [`HP_WORD_W-1:0] mem_r [0:1];
    logic wr_ptr_r;
    logic rd_ptr_r;
    logic [1:0] count_r;
    logic push;
    logic pop;

    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;
    // ready comes from the count flop so a full buffer refuses honestly
    assign in_ready = (count_r != 2'h2);
    assign out_valid = (count_r != 2'h0);
    assign out_data = mem_r[rd_ptr_r];

    // storage, no reset needed on data
    always_ff @(posedge clk) begin
        if (push) begin
            mem_r[wr_ptr_r] <= in_data;
        end
    end

    // pointers and fill count
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            wr_ptr_r <= 1'b0;
            rd_ptr_r <= 1'b0;
            count_r <= 2'h0;
        end else begin
            if (push) begin
                wr_ptr_r <= ~wr_ptr_r;
            end
            if (pop) begin
                rd_ptr_r <= ~rd_ptr_r;
            end
            if (push && !pop) begin
                count_r <= count_r + 2'h1;
            end else if (pop && !push) begin
                count_r <= count_r - 2'h1;
            end
        end
    end

endmodule : word_buffer2

// ---- testbench/host_model.sv ----
// host processor model that drives the parallel command port pins
module host_model (
    input wire logic clk,
    input wire logic ack_wire,
    input wire logic [7:0] data_wire,
    output logic strobe_n,
    output logic rnw,
    output logic cd,
    output logic wake,
    output logic [7:0] bus_h
);
    timeunit 1ns;
    timeprecision 1ns;

    // the strobe idles high and the qualifiers rest low
    initial begin
        strobe_n = 1'b1;
        rnw = 1'b0;
        cd = 1'b0;
        wake = 1'b0;
        bus_h = 8'h00;
    end

    // one transfer; the strobe is the only select that this host lowers
    task automatic xfer(input logic r, input logic c, input logic w, input logic [7:0] d,
            output logic [7:0] q, output logic ok);
        int n;
        @(posedge clk);
        rnw <= r;
        cd <= c;
        wake <= w;
        bus_h <= r ? ~bus_h : d;
        @(posedge clk);
        strobe_n <= 1'b0;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (ack_wire !== 1'b0 && n < 200);
        ok = (ack_wire === 1'b0);
        q = data_wire;
        strobe_n <= 1'b1;
        wake <= 1'b0;
        // a released bus must not keep showing the last byte
        bus_h <= ~bus_h;
        // idle gap keeps the byte rate under the ceiling
        repeat (4) @(posedge clk);
    endtask : xfer
endmodule : host_model

// ---- testbench/async_host_command_port_tb_top.sv ----
// self-checking bench for the asynchronous host command port
`include "host_port_params.svh"

module async_host_command_port_tb_top;
    import host_port_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;

    logic clk, rst_b, strobe_n, rnw, cd, wake, ack_wire, ack_n_out, ack_oe;
    logic host_data_oe, rx_valid, rx_ready, rx_is_cmd, args_abort;
    logic tx_valid, tx_taken, in_standby, wake_pulse, ok;
    logic [7:0] bus_h, host_data_in, host_data_out, rx_byte, tx_byte, q;
    logic [8:0] got_q[$];
    int bad_count, comparisons, aborts, wakes, takens, cycles;
    typedef struct {logic cd; host_byte_t b; int ab;} row_t;
    row_t rows[5] = '{'{1'b0, 8'h01, 0}, '{1'b0, 8'h80, 0}, '{1'b1, 8'ha0, 1},
        '{1'b1, 8'ha2, 0}, '{1'b0, 8'hff, 0}};

    // wire levels: ack has a pull-up, data follows whoever drives
    assign ack_wire = ack_oe ? ack_n_out : 1'b1;
    assign host_data_in = host_data_oe ? host_data_out : bus_h;

    async_host_command_port i_async_host_command_port (.clk(clk), .rst_b(rst_b),
        .select_strobe_n(strobe_n), .read_not_write(rnw), .cmd_data_sel(cd),
        .wake_request(wake), .host_data_in(host_data_in), .host_data_out(host_data_out),
        .host_data_oe(host_data_oe), .ack_n_out(ack_n_out), .ack_oe(ack_oe),
        .rx_valid(rx_valid), .rx_ready(rx_ready), .rx_byte(rx_byte), .rx_is_cmd(rx_is_cmd),
        .args_abort(args_abort), .tx_valid(tx_valid), .tx_byte(tx_byte),
        .tx_taken(tx_taken), .in_standby(in_standby), .wake_pulse(wake_pulse));

    host_model i_host_model (.clk(clk), .ack_wire(ack_wire), .data_wire(host_data_in),
        .strobe_n(strobe_n), .rnw(rnw), .cd(cd), .wake(wake), .bus_h(bus_h));

    always #50 clk = ~clk;

    // user side: collect words and pulses; a consumed read byte is withdrawn
    always @(posedge clk) begin
        if (rx_valid && rx_ready) got_q.push_back({rx_is_cmd, rx_byte});
        if (args_abort) aborts++;
        if (tx_taken) takens++;
        if (tx_taken) tx_valid <= 1'b0;
        if (wake_pulse) wakes++;
        if (wake_pulse) in_standby <= 1'b0;
        cycles++;
        if (cycles == 20000) begin
            bad_count++;
            results();
        end
    end

    task automatic check(input logic [8:0] got, input logic [8:0] exp);
        comparisons++;
        if (got !== exp) begin
            bad_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check

    task automatic results();
        $display("comparisons %0d mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : results

    initial begin
        int a;
        clk = 1'b0;
        rst_b = 1'b0;
        rx_ready = 1'b1;
        tx_valid = 1'b0;
        tx_byte = 8'h00;
        in_standby = 1'b0;
        repeat (3) @(posedge clk);
        rst_b <= 1'b1;
        @(posedge clk);
        check(ack_oe, 1'b0);
        // ordinary writes: commands, arguments and the abort they cause
        foreach (rows[i]) begin
            a = aborts;
            i_host_model.xfer(1'b0, rows[i].cd, 1'b0, rows[i].b, q, ok);
            repeat (3) @(posedge clk);
            check(ok, 1'b1);
            check(got_q.pop_front(), {rows[i].cd, rows[i].b});
            check(aborts - a, rows[i].ab);
            check(ack_oe, 1'b0);
        end
        $display("test writes done");
        // full buffer: the fourth write must not be acknowledged until drained
        rx_ready <= 1'b0;
        for (int k = 1; k < 4; k++) i_host_model.xfer(1'b0, 1'b0, 1'b0, 8'h10 + k, q, ok);
        fork
            i_host_model.xfer(1'b0, 1'b0, 1'b0, 8'h14, q, ok);
            begin
                repeat (12) @(posedge clk);
                check(ack_wire, 1'b1);
                check(ack_oe, 1'b1);
                rx_ready <= 1'b1;
            end
        join
        repeat (4) @(posedge clk);
        check(got_q.size(), 4);
        for (int k = 1; k < 5; k++) check(got_q.pop_front(), 8'h10 + k);
        $display("test stall done");
        // read waits for a valid byte before acknowledging
        tx_byte <= 8'h5a;
        fork
            i_host_model.xfer(1'b1, 1'b1, 1'b0, 8'h00, q, ok);
            begin
                repeat (8) @(posedge clk);
                check(ack_wire, 1'b1);
                check(ack_oe, 1'b1);
                tx_valid <= 1'b1;
            end
        join
        check(q, 8'h5a);
        check(takens, 1);
        check(host_data_oe, 1'b0);
        check(got_q.size(), 0);
        $display("test read done");
        // wake is ignored under a high strobe, honoured under a low one
        in_standby <= 1'b1;
        i_host_model.wake <= 1'b1;
        repeat (10) @(posedge clk);
        check(wakes, 0);
        i_host_model.wake <= 1'b0;
        i_host_model.xfer(1'b0, 1'b0, 1'b1, 8'h33, q, ok);
        check(ok, 1'b1);
        check(wakes, 1);
        check(got_q.size(), 0);
        $display("test wake done");
        // reset between edges clears a waiting word at once
        rx_ready <= 1'b0;
        i_host_model.xfer(1'b0, 1'b0, 1'b0, 8'h77, q, ok);
        #37;
        rst_b = 1'b0;
        #1;
        check(rx_valid, 1'b0);
        check(ack_oe, 1'b0);
        @(posedge clk);
        rst_b <= 1'b1;
        rx_ready <= 1'b1;
        repeat (4) @(posedge clk);
        check(got_q.size(), 0);
        $display("test reset done");
        results();
    end
endmodule : async_host_command_port_tb_top
